// ### hw/excitation_rearm_select.sv
// excitation re-arm selection after power removal, with its AXI4-Lite register slave
`timescale 1ns/1ps
module excitation_rearm_select import rearm_pkg::*; #(
    parameter int MS_CYCLES_P = MS_CYCLES
) (
    input wire logic aclk, // system clock, 20 MHz
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic power_removal_channel_a, // channel a, high = ON
    input wire logic power_removal_channel_b, // channel b, high = ON
    input wire logic cutoff_clear_input, // cutoff clear, high = ON
    input wire logic fault_reset_input, // fault reset, high = ON
    input wire logic drive_on_input, // drive on, high = ON
    input wire logic stop_input, // stop, high = ON
    output logic excitation_enable, // motor may be excited
    output logic safety_monitor_output // both channels OFF
);
    localparam int SUB_W = $clog2(MS_CYCLES_P + 1);

    // register index decode, shared by read and write paths
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        logic [9:0] idx;
        idx = addr[ADDR_W-1:2];
        unique case (idx)
            IDX_LOCKOUT: decode = SEL_LOCKOUT;
            IDX_LEVEL_SEL: decode = SEL_LEVEL;
            IDX_FAULT_EN: decode = SEL_FAULT;
            IDX_DRIVE_EN: decode = SEL_DRIVE;
            IDX_STOP_EN: decode = SEL_STOP;
            IDX_STATUS: decode = SEL_STATUS;
            default: decode = SEL_NONE;
        endcase
    endfunction

    logic [IN_N-1:0] lvl;
    logic [IN_N-1:0] rise;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic wstrb0_r;
    logic [1:0] level_sel_r;
    logic fault_en_r, drive_en_r, stop_en_r;
    logic [6:0] lockout_ms_r;
    logic [SUB_W-1:0] sub_r;
    logic [6:0] ms_cnt_r;
    rearm_state_t st_r;
    logic excite_r, monitor_r;
    logic both_on, lockout_done, clear_req, other_req, rearm_req;
    logic write_go;
    reg_sel_t wsel;

    // all control pins cross into aclk before anything looks at them
    input_sync #(.N(IN_N)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({stop_input, drive_on_input, fault_reset_input, cutoff_clear_input,
                 power_removal_channel_b, power_removal_channel_a}),
        .level_out(lvl),
        .rise_out(rise)
    );

    // request qualification
    assign both_on = lvl[IN_CH_A] & lvl[IN_CH_B];
    assign lockout_done = (ms_cnt_r >= lockout_ms_r);
    assign clear_req = lockout_done & ((level_sel_r == LVL_LEVEL) ? lvl[IN_CLEAR] : rise[IN_CLEAR]);
    assign other_req = (fault_en_r & rise[IN_FAULT])
        | (drive_en_r & rise[IN_DRIVE])
        | (stop_en_r & rise[IN_STOP]);
    assign rearm_req = clear_req | other_req;

    // cutoff / wait / excited sequencing; loss of either channel always wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= ST_CUTOFF;
        end else if (!both_on) begin
            st_r <= ST_CUTOFF;
        end else begin
            unique case (st_r)
                ST_CUTOFF: st_r <= ST_WAIT;
                ST_WAIT: if (rearm_req) begin
                    st_r <= ST_EXCITED;
                end
                ST_EXCITED: st_r <= ST_EXCITED;
                default: st_r <= ST_CUTOFF;
            endcase
        end
    end

    // lockout timer runs only while waiting for a re-arm; saturates at the limit
    always_ff @(posedge aclk) begin
        if (!aresetn || st_r != ST_WAIT) begin
            sub_r <= '0;
            ms_cnt_r <= 7'h00;
        end else if (!lockout_done) begin
            if (sub_r == SUB_W'(MS_CYCLES_P - 1)) begin
                sub_r <= '0;
                ms_cnt_r <= ms_cnt_r + 7'h01;
            end else begin
                sub_r <= sub_r + SUB_W'(1);
            end
        end
    end

    // outputs straight from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            excite_r <= 1'b0;
            monitor_r <= 1'b0;
        end else begin
            excite_r <= (st_r == ST_EXCITED) & both_on;
            monitor_r <= ~lvl[IN_CH_A] & ~lvl[IN_CH_B];
        end
    end
    assign excitation_enable = excite_r;
    assign safety_monitor_output = monitor_r;

    // write address and data taken in either order, response once both held
    assign write_go = !awready_r && !wready_r && !bvalid_r;
    assign wsel = decode(awaddr_r);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb0_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awready_r <= 1'b0;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_r) begin
                wready_r <= 1'b0;
                wdata_r <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (write_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // configuration registers; all fields live in byte lane 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_sel_r <= LEVEL_SEL_RST;
            fault_en_r <= FAULT_EN_RST;
            drive_en_r <= DRIVE_EN_RST;
            stop_en_r <= STOP_EN_RST;
            lockout_ms_r <= LOCKOUT_RST;
        end else if (write_go && wstrb0_r) begin
            unique case (wsel)
                SEL_LEVEL: if (wdata_r[31:0] == 32'(LVL_EDGE) || wdata_r[31:0] == 32'(LVL_LEVEL)) begin
                    level_sel_r <= wdata_r[1:0];
                end
                SEL_FAULT: fault_en_r <= wdata_r[0];
                SEL_DRIVE: drive_en_r <= wdata_r[0];
                SEL_STOP: stop_en_r <= wdata_r[0];
                SEL_LOCKOUT: lockout_ms_r <= (wdata_r > 32'(LOCKOUT_MAX_MS)) ? LOCKOUT_MAX_MS
                    : wdata_r[6:0];
                SEL_NONE, SEL_STATUS: lockout_ms_r <= lockout_ms_r;
            endcase
        end
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            unique case (decode(s_axi_araddr))
                SEL_LOCKOUT: rdata_r <= {25'h0000000, lockout_ms_r};
                SEL_LEVEL: rdata_r <= {30'h00000000, level_sel_r};
                SEL_FAULT: rdata_r <= {31'h00000000, fault_en_r};
                SEL_DRIVE: rdata_r <= {31'h00000000, drive_en_r};
                SEL_STOP: rdata_r <= {31'h00000000, stop_en_r};
                SEL_STATUS: begin
                    rdata_r <= 32'h0000_0000;
                    rdata_r[ST_BIT_EXCITED] <= excite_r;
                    rdata_r[ST_BIT_MONITOR] <= monitor_r;
                    rdata_r[ST_BIT_BOTH_ON] <= both_on;
                    rdata_r[ST_BIT_LOCKOUT] <= (st_r == ST_WAIT) && !lockout_done;
                end
                SEL_NONE: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // checks on the sequencing
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ready_wait;
        st_r == ST_WAIT && both_on;
    endsequence
    sequence s_excited_out;
        st_r == ST_EXCITED ##1 excitation_enable;
    endsequence

    property p_level_sel_legal;
        level_sel_r == LVL_EDGE || level_sel_r == LVL_LEVEL;
    endproperty
    a_level_sel_legal: assert property (p_level_sel_legal)
        else $error("judgment setting left its legal values");

    property p_level_mode_rearm;
        s_ready_wait ##0 (level_sel_r == LVL_LEVEL && lvl[IN_CLEAR] && lockout_done) |=> s_excited_out;
    endproperty
    a_level_mode_rearm: assert property (p_level_mode_rearm)
        else $error("clear level did not re-excite in level mode");

    property p_fault_rearm;
        s_ready_wait ##0 (fault_en_r && rise[IN_FAULT]) |=> s_excited_out;
    endproperty
    a_fault_rearm: assert property (p_fault_rearm)
        else $error("enabled fault reset edge did not re-excite");

    property p_drive_rearm;
        s_ready_wait ##0 (drive_en_r && rise[IN_DRIVE]) |=> st_r == ST_EXCITED;
    endproperty
    a_drive_rearm: assert property (p_drive_rearm)
        else $error("enabled drive-on edge did not re-excite");

    property p_stop_rearm;
        s_ready_wait ##0 (stop_en_r && rise[IN_STOP]) |=> st_r == ST_EXCITED;
    endproperty
    a_stop_rearm: assert property (p_stop_rearm)
        else $error("enabled stop edge did not re-excite");

    property p_off_blocks;
        !both_on |=> st_r == ST_CUTOFF ##1 !excitation_enable;
    endproperty
    a_off_blocks: assert property (p_off_blocks)
        else $error("excitation allowed with a channel off");

    property p_lockout_holds;
        (st_r == ST_WAIT && !lockout_done && !other_req) |=> st_r != ST_EXCITED;
    endproperty
    a_lockout_holds: assert property (p_lockout_holds)
        else $error("cutoff clear accepted inside the lockout");

    // the flop still sits in reset on the release edge, so wait one full cycle out of reset
    property p_monitor;
        (!lvl[IN_CH_A] && !lvl[IN_CH_B] && $past(aresetn)) |=> safety_monitor_output;
    endproperty
    a_monitor: assert property (p_monitor)
        else $error("monitor output missing with both channels off");

    property p_monitor_low;
        (lvl[IN_CH_A] || lvl[IN_CH_B]) |=> !safety_monitor_output;
    endproperty
    a_monitor_low: assert property (p_monitor_low)
        else $error("monitor output set with a channel on");
endmodule // excitation_rearm_select

// ### hw/rearm_pkg.sv
// package: register map, field layout and timing constants for the excitation re-arm block
package rearm_pkg;
    // clock and lockout time base
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_LOCKOUT = 10'h198;
    localparam logic [9:0] IDX_LEVEL_SEL = 10'h199;
    localparam logic [9:0] IDX_FAULT_EN = 10'h19A;
    localparam logic [9:0] IDX_DRIVE_EN = 10'h19B;
    localparam logic [9:0] IDX_STOP_EN = 10'h19C;
    localparam logic [9:0] IDX_STATUS = 10'h1A0;
    localparam int ADDR_W = 12;

    // field values and reset values
    localparam logic [1:0] LVL_EDGE = 2'h1;
    localparam logic [1:0] LVL_LEVEL = 2'h2;
    localparam logic [1:0] LEVEL_SEL_RST = 2'h1;
    localparam logic FAULT_EN_RST = 1'h0;
    localparam logic DRIVE_EN_RST = 1'h0;
    localparam logic STOP_EN_RST = 1'h1;
    localparam logic [6:0] LOCKOUT_RST = 7'h00;
    localparam logic [6:0] LOCKOUT_MAX_MS = 7'h64;

    // status register bit positions
    localparam int ST_BIT_EXCITED = 0;
    localparam int ST_BIT_MONITOR = 1;
    localparam int ST_BIT_BOTH_ON = 2;
    localparam int ST_BIT_LOCKOUT = 3;

    // synchronised input vector positions
    localparam int IN_N = 6;
    localparam int IN_CH_A = 0;
    localparam int IN_CH_B = 1;
    localparam int IN_CLEAR = 2;
    localparam int IN_FAULT = 3;
    localparam int IN_DRIVE = 4;
    localparam int IN_STOP = 5;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_CUTOFF = 2'b00,
        ST_WAIT = 2'b01,
        ST_EXCITED = 2'b10
    } rearm_state_t;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_LOCKOUT = 3'b001,
        SEL_LEVEL = 3'b010,
        SEL_FAULT = 3'b011,
        SEL_DRIVE = 3'b100,
        SEL_STOP = 3'b101,
        SEL_STATUS = 3'b110
    } reg_sel_t;
endpackage

// ### hw/input_sync.sv
// two-flop synchroniser bank with ON-edge detection per input
`timescale 1ns/1ps
module input_sync import rearm_pkg::*; #(
    parameter int N = IN_N
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [N-1:0] pin_in, // raw asynchronous inputs
    output logic [N-1:0] level_out, // synchronised level
    output logic [N-1:0] rise_out // one-cycle ON-edge pulse
);
    logic [N-1:0] meta_r;
    logic [N-1:0] sync_r;
    logic [N-1:0] prev_r;

    // first stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta_r[i] <= 1'b0;
                    sync_r[i] <= 1'b0;
                    prev_r[i] <= 1'b0;
                end else begin
                    meta_r[i] <= pin_in[i];
                    sync_r[i] <= meta_r[i];
                    prev_r[i] <= sync_r[i];
                end
            end
        end
    endgenerate

    assign level_out = sync_r;
    assign rise_out = sync_r & ~prev_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_edge_needs_off_sample;
        rise_out != '0 |-> ((level_out & $past(~level_out)) & rise_out) == rise_out;
    endproperty
    a_edge_needs_off_sample: assert property (p_edge_needs_off_sample)
        else $error("on edge flagged without an off sample before it");
endmodule // input_sync

// ### tb/host_ctrl_model.sv
// host controller model that drives the driver's control pins
`timescale 1ns/1ps
module host_ctrl_model import rearm_pkg::*; (
    input wire logic aclk, // system clock
    output logic [IN_N-1:0] pins // control pins in sync-vector order, high = ON
);
    // all pins OFF until the bench asks otherwise
    initial begin
        pins = '0;
    end

    // level change one edge later, by non-blocking assignment
    task automatic set_pin(input int idx, input logic v);
        @(posedge aclk);
        pins[idx] <= v;
    endtask

    // three clocks ON then three OFF, so the two-flop sampler sees both levels
    task automatic pulse(input int idx);
        set_pin(idx, 1'b1);
        repeat (3) @(posedge aclk);
        pins[idx] <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
endmodule // host_ctrl_model

// ### tb/testbench.sv
// self-checking bench for the excitation re-arm block with a scoreboard queue
`timescale 1ns/1ps
module testbench import rearm_pkg::*; ;
    localparam int MS_SIM = 4;
    localparam logic [11:0] A_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [11:0] A_LOCK = {IDX_LOCKOUT, 2'b00};
    localparam logic [11:0] A_LEVEL = {IDX_LEVEL_SEL, 2'b00};
    localparam logic [11:0] A_HOLE = 12'h674;
    logic aclk, aresetn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, excitation_enable, safety_monitor_output;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [IN_N-1:0] pins;
    logic [33:0] exp_q[$];
    logic [1:0] out_q[$]; // expected {monitor, excited} pins for each status read
    logic [11:0] a_tab[5] = '{A_LOCK, A_LEVEL, {IDX_FAULT_EN, 2'b00}, {IDX_DRIVE_EN, 2'b00}, {IDX_STOP_EN, 2'b00}};
    logic [31:0] rst_tab[5] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h1};
    int bad_count, samples_checked, cycles;

    excitation_rearm_select #(.MS_CYCLES_P(MS_SIM)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .power_removal_channel_a(pins[IN_CH_A]), .power_removal_channel_b(pins[IN_CH_B]),
        .cutoff_clear_input(pins[IN_CLEAR]), .fault_reset_input(pins[IN_FAULT]),
        .drive_on_input(pins[IN_DRIVE]), .stop_input(pins[IN_STOP]),
        .excitation_enable(excitation_enable), .safety_monitor_output(safety_monitor_output)
    );

    host_ctrl_model i_host (
        .aclk(aclk),
        .pins(pins)
    );

    // free-running 50 ns clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // watcher: each bus answer takes the oldest expectation off the queue
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            check({s_axi_bresp, 32'h0}, exp_q.pop_front());
        end
        if (s_axi_rvalid && s_axi_rready) begin
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
            if (s_axi_araddr == A_STATUS) begin
                check({32'h0, safety_monitor_output, excitation_enable}, {32'h0, out_q.pop_front()});
            end
        end
    end

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        bit aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        exp_q.push_back({r, 32'h0});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({r, d});
        if (a == A_STATUS) out_q.push_back(d[1:0]);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    task automatic settle();
        repeat (12) @(posedge aclk);
    endtask

    // random channel drop to cutoff, then both channels back ON
    task automatic rearm(input bit early);
        int drop;
        drop = $urandom_range(3, 1);
        if (drop[0]) i_host.set_pin(IN_CH_A, 1'b0);
        if (drop[1]) i_host.set_pin(IN_CH_B, 1'b0);
        settle();
        axi_read(A_STATUS, (pins[IN_CH_A] || pins[IN_CH_B]) ? 32'h0 : 32'h2, RESP_OKAY);
        i_host.set_pin(IN_CH_A, 1'b1);
        i_host.set_pin(IN_CH_B, 1'b1);
        // an early clear pulse lands inside the lockout window
        if (early) i_host.pulse(IN_CLEAR);
        repeat (16) @(posedge aclk);
    endtask

    // main sequence
    initial begin
        void'($urandom(13031));
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        for (int i = 0; i < 5; i++) begin
            axi_read(a_tab[i], rst_tab[i], RESP_OKAY);
        end
        axi_read(A_STATUS, 32'h2, RESP_OKAY);
        axi_read(A_HOLE, 32'h0, RESP_SLVERR);
        axi_write(A_HOLE, 32'h1, RESP_SLVERR);
        // requests while a channel is OFF do nothing
        i_host.pulse(IN_STOP);
        axi_read(A_STATUS, 32'h2, RESP_OKAY);
        i_host.set_pin(IN_CH_A, 1'b1);
        settle();
        i_host.pulse(IN_STOP);
        axi_read(A_STATUS, 32'h0, RESP_OKAY);
        // each extra input: disabled edge ignored, enabled edge re-excites
        for (int i = 0; i < 3; i++) begin
            axi_write(a_tab[2 + i], 32'h0, RESP_OKAY);
            rearm(1'b0);
            i_host.pulse(IN_FAULT + i);
            settle();
            axi_read(A_STATUS, 32'h4, RESP_OKAY);
            axi_write(a_tab[2 + i], 32'h1, RESP_OKAY);
            i_host.pulse(IN_FAULT + i);
            settle();
            axi_read(A_STATUS, 32'h5, RESP_OKAY);
        end
        // edge mode clear
        rearm(1'b0);
        i_host.pulse(IN_CLEAR);
        settle();
        axi_read(A_STATUS, 32'h5, RESP_OKAY);
        // level mode: clear held ON re-excites without a new edge
        axi_write(A_LEVEL, 32'h2, RESP_OKAY);
        axi_write(A_LEVEL, 32'h3, RESP_OKAY);
        axi_read(A_LEVEL, 32'h2, RESP_OKAY);
        // byte lane 0 off: write answered but the setting stays
        s_axi_wstrb <= 4'($urandom) & 4'hE;
        axi_write(A_LEVEL, 32'h1, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axi_read(A_LEVEL, 32'h2, RESP_OKAY);
        i_host.set_pin(IN_CLEAR, 1'b1);
        rearm(1'b0);
        axi_read(A_STATUS, 32'h5, RESP_OKAY);
        // lockout clamps at 100 ms and masks an early clear edge
        axi_write(A_LOCK, 32'hC8, RESP_OKAY);
        axi_read(A_LOCK, 32'h64, RESP_OKAY);
        axi_write(A_LOCK, 32'h105, RESP_OKAY);
        axi_read(A_LOCK, 32'h64, RESP_OKAY);
        axi_write(A_LOCK, 32'h2, RESP_OKAY);
        rearm(1'b0);
        axi_read(A_STATUS, 32'h5, RESP_OKAY);
        axi_write(A_LEVEL, 32'h1, RESP_OKAY);
        i_host.set_pin(IN_CLEAR, 1'b0);
        rearm(1'b1);
        axi_read(A_STATUS, 32'h4, RESP_OKAY);
        i_host.pulse(IN_CLEAR);
        settle();
        axi_read(A_STATUS, 32'h5, RESP_OKAY);
        stop_test();
    end
endmodule // testbench
